// ==== nvcfg_pkg.sv ====
package nvcfg_pkg;

  // Bus constants
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 11;
  localparam int IDX_W = IDX_MSB - IDX_LSB + 1;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;

  // Register indices; the byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_UPPER_DIAG = 10'h0C5;
  localparam logic [IDX_W-1:0] IDX_REG_DIM_ADDR = 10'h0C6;
  localparam logic [IDX_W-1:0] IDX_PWM_FAIL = 10'h0C7;
  localparam logic [IDX_W-1:0] IDX_TMO_SUPPLY = 10'h0C8;

  // Reset values
  localparam logic [REG_W-1:0] RST_UPPER_DIAG = 8'h0F;
  localparam logic [REG_W-1:0] RST_REG_DIM_ADDR = 8'h00;
  localparam logic [REG_W-1:0] RST_PWM_FAIL = 8'hA7;
  localparam logic [REG_W-1:0] RST_TMO_SUPPLY = 8'h03;

  // Writable bits; the rest are reserved and read zero
  localparam logic [REG_W-1:0] WMASK_UPPER_DIAG = 8'h0F;
  localparam logic [REG_W-1:0] WMASK_REG_DIM_ADDR = 8'h5F;
  localparam logic [REG_W-1:0] WMASK_PWM_FAIL = 8'hFF;
  localparam logic [REG_W-1:0] WMASK_TMO_SUPPLY = 8'h7F;

  // Field layout
  localparam int DIAG_LSB = 0;
  localparam int DIAG_W = 4;
  localparam int REG_SEL_BIT = 6;
  localparam int EXP_DIM_BIT = 4;
  localparam int DEV_ADDR_LSB = 0;
  localparam int DEV_ADDR_W = 4;
  localparam int PWM_CODE_LSB = 4;
  localparam int PWM_CODE_W = 4;
  localparam int ADDR_SRC_BIT = 3;
  localparam int FAIL_POLICY_BIT = 2;
  localparam int REF_CODE_LSB = 0;
  localparam int REF_CODE_W = 2;
  localparam int TMO_CODE_LSB = 4;
  localparam int TMO_CODE_W = 3;
  localparam int SUPPLY_CODE_LSB = 0;
  localparam int SUPPLY_CODE_W = 4;
  localparam int STRAP_W = 3;

  // Setting encodings
  localparam logic REG_SEL_5V0 = 1'h0;
  localparam logic REG_SEL_4V4 = 1'h1;
  localparam logic ADDR_FROM_STRAPS = 1'h0;
  localparam logic ADDR_FROM_STORED = 1'h1;
  localparam logic FAIL_OTHERS_ON = 1'h0;
  localparam logic FAIL_ALL = 1'h1;

  // Decode tables
  localparam int PWM_HZ_W = 15;
  localparam int PWM_FREQ_HZ [16] = '{200, 250, 300, 350, 400, 500, 600, 800,
                                      1000, 1200, 2000, 4000, 5900, 7800, 9600, 20800};
  localparam int RATIO_W = 10;
  localparam int REF_RATIO [4] = '{64, 128, 256, 512};
  localparam int TMO_CYC_W = 20;
  localparam int TIMEOUT_US [8] = '{1000, 125, 250, 500, 1250, 2500, 5000, 10000};
  localparam int NS_PER_US = 1000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int SUPPLY_V_W = 5;
  localparam int SUPPLY_BASE_V = 5;
  localparam int SUPPLY_STEP_V = 1;

endpackage

// ==== strap_sync.sv ====
module strap_sync
  import nvcfg_pkg::*;
#(
  parameter int WIDTH = STRAP_W
)
(
  input wire logic hclk, // System clock
  input wire logic hresetn, // Asynchronous reset, active low
  input wire logic [WIDTH-1:0] pin_in, // Raw strap pins
  output logic [WIDTH-1:0] level_out // Filtered strap levels
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          stage1_reg[i] <= 1'h0;
          stage2_reg[i] <= 1'h0;
          stage3_reg[i] <= 1'h0;
          level_out[i] <= 1'h0;
        end
        else
        begin
          stage1_reg[i] <= pin_in[i];
          stage2_reg[i] <= stage1_reg[i];
          stage3_reg[i] <= stage2_reg[i];
          // Accept a new level only once two later stages agree
          if (stage2_reg[i] == stage3_reg[i])
          begin
            level_out[i] <= stage3_reg[i];
          end
        end
      end
    end
  endgenerate

endmodule

// ==== setting_decoder.sv ====
module setting_decoder
  import nvcfg_pkg::*;
#(
  parameter int PERIOD_NS = CLK_PERIOD_NS
)
(
  input wire logic [PWM_CODE_W-1:0] pwm_frequency_code, // PWM frequency code
  input wire logic [REF_CODE_W-1:0] reference_ratio_code, // Reference ratio code
  input wire logic [TMO_CODE_W-1:0] link_timeout_code, // Link timeout code
  input wire logic [SUPPLY_CODE_W-1:0] low_supply_threshold_code, // Supply threshold code
  output logic [PWM_HZ_W-1:0] pwm_hz, // PWM frequency in Hz
  output logic [RATIO_W-1:0] ratio, // Reference current ratio
  output logic [TMO_CYC_W-1:0] timeout_cycles, // Link timeout in clock cycles
  output logic [SUPPLY_V_W-1:0] supply_v // Low-supply threshold in volts
);

  always_comb
  begin
    pwm_hz = PWM_HZ_W'(PWM_FREQ_HZ[pwm_frequency_code]);
    ratio = RATIO_W'(REF_RATIO[reference_ratio_code]);
    // Never longer than the set timeout, as the division rounds down
    timeout_cycles = TMO_CYC_W'(TIMEOUT_US[link_timeout_code] * NS_PER_US / PERIOD_NS);
    supply_v = SUPPLY_V_W'(SUPPLY_BASE_V + SUPPLY_STEP_V * int'(low_supply_threshold_code));
  end

endmodule

// ==== nvcfg_bank.sv ====
// Notes on behaviour
// - Bits 0-3 enable diagnostics on channels 8-11; each resets enabled.
// - Regulator select resets zero; zero means 5.0 V, one means 4.4 V.
// - Bit 4 enables exponential dimming; resets off, otherwise linear dimming.
// - Stored 4-bit device address in bits 3-0, reset zero, used as-is.
// - PWM frequency code resets Ah, decodes to 200 Hz up to 20.8 kHz.
// - Bit 3 clear takes address from strap pins; set takes stored address.
// - Failure policy bit 2 resets one; one makes any failure fail all.
// - Ratio code bits 1-0 resets 3h, selects 64, 128, 256 or 512.
// - Link timeout code bits 6-4 resets zero (1 ms), selects 125 us up to 10 ms.
// - Supply threshold code bits 3-0 resets 3h, 5 V plus 1 V per step.
module nvcfg_bank
  import nvcfg_pkg::*;
#(
  parameter int PERIOD_NS = CLK_PERIOD_NS
)
(
  input wire logic hclk, // Bus clock
  input wire logic hresetn, // Asynchronous reset, active low
  input wire logic hsel, // Slave select
  input wire logic [DATA_W-1:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size
  input wire logic [DATA_W-1:0] hwdata, // Write data
  input wire logic hready, // Bus ready in
  output logic hreadyout, // Slave ready
  output logic hresp, // Response
  output logic [DATA_W-1:0] hrdata, // Read data
  input wire logic address_strap_pin_2, // Address strap, bit 2
  input wire logic address_strap_pin_1, // Address strap, bit 1
  input wire logic address_strap_pin_0, // Address strap, bit 0
  output logic diag_enable_ch_eight, // Diagnostics enable, channel 8
  output logic diag_enable_ch_nine, // Diagnostics enable, channel 9
  output logic diag_enable_ch_ten, // Diagnostics enable, channel 10
  output logic diag_enable_ch_eleven, // Diagnostics enable, channel 11
  output logic regulator_voltage_select, // 0: 5.0 V, 1: 4.4 V
  output logic exponential_dimming_enable, // Exponential dimming on
  output logic address_source_select, // 0: straps, 1: stored address
  output logic [DEV_ADDR_W-1:0] device_address, // Effective device address
  output logic failure_policy_select, // 1: one fails all fail
  output logic [PWM_HZ_W-1:0] pwm_frequency_hz, // PWM frequency in Hz
  output logic [RATIO_W-1:0] reference_ratio, // Reference current ratio
  output logic [TMO_CYC_W-1:0] link_timeout_cycles, // Link timeout in cycles
  output logic [SUPPLY_V_W-1:0] low_supply_threshold_v // Supply threshold in volts
);

  // Storage
  logic [REG_W-1:0] upper_channel_diag_enable_reg;
  logic [REG_W-1:0] regulator_dimming_address_config_reg;
  logic [REG_W-1:0] pwm_frequency_failure_policy_config_reg;
  logic [REG_W-1:0] link_timeout_supply_threshold_config_reg;

  logic [REG_W-1:0] upper_channel_diag_enable_next;
  logic [REG_W-1:0] regulator_dimming_address_config_next;
  logic [REG_W-1:0] pwm_frequency_failure_policy_config_next;
  logic [REG_W-1:0] link_timeout_supply_threshold_config_next;

  // Data-phase bookkeeping
  logic wr_pending_reg;
  logic [IDX_W-1:0] wr_idx_reg;
  logic [DATA_W-1:0] hrdata_reg;
  logic [DATA_W-1:0] hrdata_next;

  logic addr_phase;
  logic [IDX_W-1:0] addr_idx;
  logic [REG_W-1:0] wr_byte;

  // Strap path
  logic [STRAP_W-1:0] strap_level;

  // Decoder results
  logic [PWM_HZ_W-1:0] pwm_hz;
  logic [RATIO_W-1:0] ratio;
  logic [TMO_CYC_W-1:0] timeout_cycles;
  logic [SUPPLY_V_W-1:0] supply_v;
  logic [DEV_ADDR_W-1:0] device_address_next;

  // Zero-wait slave: every transfer completes in one data phase
  assign hreadyout = 1'h1;
  assign hresp = HRESP_OKAY;
  assign hrdata = hrdata_reg;

  assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign addr_idx = haddr[IDX_MSB:IDX_LSB];
  assign wr_byte = hwdata[REG_W-1:0];

  // Address phase capture for writes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pending_reg <= 1'h0;
      wr_idx_reg <= '0;
    end
    else
    begin
      wr_pending_reg <= addr_phase && hwrite;
      if (addr_phase)
      begin
        wr_idx_reg <= addr_idx;
      end
    end
  end

  // Write data lands in the data phase; reserved bits are masked off
  always_comb
  begin
    upper_channel_diag_enable_next = upper_channel_diag_enable_reg;
    regulator_dimming_address_config_next = regulator_dimming_address_config_reg;
    pwm_frequency_failure_policy_config_next = pwm_frequency_failure_policy_config_reg;
    link_timeout_supply_threshold_config_next = link_timeout_supply_threshold_config_reg;
    if (wr_pending_reg)
    begin
      case (wr_idx_reg)
        IDX_UPPER_DIAG:
        begin
          upper_channel_diag_enable_next = wr_byte & WMASK_UPPER_DIAG;
        end
        IDX_REG_DIM_ADDR:
        begin
          regulator_dimming_address_config_next = wr_byte & WMASK_REG_DIM_ADDR;
        end
        IDX_PWM_FAIL:
        begin
          pwm_frequency_failure_policy_config_next = wr_byte & WMASK_PWM_FAIL;
        end
        IDX_TMO_SUPPLY:
        begin
          link_timeout_supply_threshold_config_next = wr_byte & WMASK_TMO_SUPPLY;
        end
        default:
        begin
          upper_channel_diag_enable_next = upper_channel_diag_enable_reg;
        end
      endcase
    end
  end

  // Setting storage with documented reset values
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      upper_channel_diag_enable_reg <= RST_UPPER_DIAG;
      regulator_dimming_address_config_reg <= RST_REG_DIM_ADDR;
      pwm_frequency_failure_policy_config_reg <= RST_PWM_FAIL;
      link_timeout_supply_threshold_config_reg <= RST_TMO_SUPPLY;
    end
    else
    begin
      upper_channel_diag_enable_reg <= upper_channel_diag_enable_next;
      regulator_dimming_address_config_reg <= regulator_dimming_address_config_next;
      pwm_frequency_failure_policy_config_reg <= pwm_frequency_failure_policy_config_next;
      link_timeout_supply_threshold_config_reg <= link_timeout_supply_threshold_config_next;
    end
  end

  // Read data is sampled from the next values, so a read right after a
  // write to the same register already sees the new contents
  always_comb
  begin
    hrdata_next = '0;
    case (addr_idx)
      IDX_UPPER_DIAG:
      begin
        hrdata_next[REG_W-1:0] = upper_channel_diag_enable_next;
      end
      IDX_REG_DIM_ADDR:
      begin
        hrdata_next[REG_W-1:0] = regulator_dimming_address_config_next;
      end
      IDX_PWM_FAIL:
      begin
        hrdata_next[REG_W-1:0] = pwm_frequency_failure_policy_config_next;
      end
      IDX_TMO_SUPPLY:
      begin
        hrdata_next[REG_W-1:0] = link_timeout_supply_threshold_config_next;
      end
      default:
      begin
        hrdata_next = '0;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata_reg <= '0;
    end
    else if (addr_phase && !hwrite)
    begin
      hrdata_reg <= hrdata_next;
    end
  end

  strap_sync #(
    .WIDTH(STRAP_W)
  ) u_strap_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in({address_strap_pin_2, address_strap_pin_1, address_strap_pin_0}),
    .level_out(strap_level)
  );

  setting_decoder #(
    .PERIOD_NS(PERIOD_NS)
  ) u_setting_decoder (
    .pwm_frequency_code(pwm_frequency_failure_policy_config_reg[PWM_CODE_LSB +: PWM_CODE_W]),
    .reference_ratio_code(pwm_frequency_failure_policy_config_reg[REF_CODE_LSB +: REF_CODE_W]),
    .link_timeout_code(link_timeout_supply_threshold_config_reg[TMO_CODE_LSB +: TMO_CODE_W]),
    .low_supply_threshold_code(
      link_timeout_supply_threshold_config_reg[SUPPLY_CODE_LSB +: SUPPLY_CODE_W]),
    .pwm_hz(pwm_hz),
    .ratio(ratio),
    .timeout_cycles(timeout_cycles),
    .supply_v(supply_v)
  );

  // Address source choice; straps cover the lower three address bits
  always_comb
  begin
    if (pwm_frequency_failure_policy_config_reg[ADDR_SRC_BIT] == ADDR_FROM_STORED)
    begin
      device_address_next =
        regulator_dimming_address_config_reg[DEV_ADDR_LSB +: DEV_ADDR_W];
    end
    else
    begin
      device_address_next = {1'h0, strap_level};
    end
  end

  // Settings presented to the function logic
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      diag_enable_ch_eight <= RST_UPPER_DIAG[DIAG_LSB];
      diag_enable_ch_nine <= RST_UPPER_DIAG[DIAG_LSB + 1];
      diag_enable_ch_ten <= RST_UPPER_DIAG[DIAG_LSB + 2];
      diag_enable_ch_eleven <= RST_UPPER_DIAG[DIAG_LSB + 3];
      regulator_voltage_select <= RST_REG_DIM_ADDR[REG_SEL_BIT];
      exponential_dimming_enable <= RST_REG_DIM_ADDR[EXP_DIM_BIT];
      address_source_select <= RST_PWM_FAIL[ADDR_SRC_BIT];
      failure_policy_select <= RST_PWM_FAIL[FAIL_POLICY_BIT];
    end
    else
    begin
      diag_enable_ch_eight <= upper_channel_diag_enable_reg[DIAG_LSB];
      diag_enable_ch_nine <= upper_channel_diag_enable_reg[DIAG_LSB + 1];
      diag_enable_ch_ten <= upper_channel_diag_enable_reg[DIAG_LSB + 2];
      diag_enable_ch_eleven <= upper_channel_diag_enable_reg[DIAG_LSB + 3];
      regulator_voltage_select <= regulator_dimming_address_config_reg[REG_SEL_BIT];
      exponential_dimming_enable <= regulator_dimming_address_config_reg[EXP_DIM_BIT];
      address_source_select <= pwm_frequency_failure_policy_config_reg[ADDR_SRC_BIT];
      failure_policy_select <= pwm_frequency_failure_policy_config_reg[FAIL_POLICY_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      device_address <= '0;
      pwm_frequency_hz <= '0;
      reference_ratio <= '0;
      link_timeout_cycles <= '0;
      low_supply_threshold_v <= '0;
    end
    else
    begin
      device_address <= device_address_next;
      pwm_frequency_hz <= pwm_hz;
      reference_ratio <= ratio;
      link_timeout_cycles <= timeout_cycles;
      low_supply_threshold_v <= supply_v;
    end
  end

endmodule

// ==== nvcfg_bank_checker.sv ====
module nvcfg_bank_checker
  import nvcfg_pkg::*;
#(
  parameter int PERIOD_NS = CLK_PERIOD_NS
)
(
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset
  input wire logic hsel, // Select
  input wire logic [DATA_W-1:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer
  input wire logic hwrite, // Write
  input wire logic [DATA_W-1:0] hwdata, // Write data
  input wire logic hready, // Ready in
  input wire logic [DATA_W-1:0] hrdata, // Read data
  input wire logic diag_enable_ch_eight, // Diag 8
  input wire logic diag_enable_ch_nine, // Diag 9
  input wire logic diag_enable_ch_ten, // Diag 10
  input wire logic diag_enable_ch_eleven, // Diag 11
  input wire logic regulator_voltage_select, // Regulator
  input wire logic exponential_dimming_enable, // Dimming
  input wire logic address_source_select, // Source
  input wire logic [DEV_ADDR_W-1:0] device_address, // Address
  input wire logic failure_policy_select, // Policy
  input wire logic [PWM_HZ_W-1:0] pwm_frequency_hz, // PWM
  input wire logic [RATIO_W-1:0] reference_ratio, // Ratio
  input wire logic [SUPPLY_V_W-1:0] low_supply_threshold_v // Threshold
);
  timeunit 1ns;
  timeprecision 1ns;
  logic dp_wr;
  logic dp_rd;
  logic [IDX_W-1:0] dp_idx;
  logic [REG_W-1:0] byte_d1;
  logic [REG_W-1:0] byte_d2;
  // Marks the data phase of a taken transfer
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_wr <= 1'b0;
      dp_rd <= 1'b0;
      dp_idx <= '0;
    end
    else
    begin
      dp_wr <= hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
      dp_rd <= hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
      dp_idx <= haddr[IDX_MSB:IDX_LSB];
    end
  end
  // Write byte delayed to line up with the setting outputs
  always_ff @(posedge hclk)
  begin
    byte_d1 <= hwdata[REG_W-1:0];
    byte_d2 <= byte_d1;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_wr(logic [IDX_W-1:0] idx);
    dp_wr && dp_idx == idx;
  endsequence
  a_diag_write_follow: assert property (s_wr(IDX_UPPER_DIAG) |-> ##2
    {diag_enable_ch_eleven, diag_enable_ch_ten, diag_enable_ch_nine, diag_enable_ch_eight}
    == byte_d2[3:0]) else $error("diag enables do not follow write");
  a_reg_dim_follow: assert property (s_wr(IDX_REG_DIM_ADDR) |-> ##2
    regulator_voltage_select == byte_d2[6] && exponential_dimming_enable == byte_d2[4])
    else $error("regulator or dimming select wrong");
  a_src_policy_follow: assert property (s_wr(IDX_PWM_FAIL) |-> ##2
    address_source_select == byte_d2[3] && failure_policy_select == byte_d2[2])
    else $error("source or policy select wrong");
  a_ratio_decode: assert property (s_wr(IDX_PWM_FAIL) |-> ##2
    reference_ratio == (10'h040 << byte_d2[1:0])) else $error("ratio decode wrong");
  a_supply_decode: assert property (s_wr(IDX_TMO_SUPPLY) |-> ##2
    low_supply_threshold_v == 5'h05 + {1'b0, byte_d2[3:0]}) else $error("threshold wrong");
  a_stored_addr_use: assert property (dp_wr && dp_idx == IDX_REG_DIM_ADDR &&
    address_source_select |-> ##2 device_address == byte_d2[3:0]) else $error("stored addr");
  a_strap_addr_top: assert property (!address_source_select &&
    !$past(address_source_select) |-> device_address[3] == 1'b0) else $error("strap addr");
  a_reset_decode: assert property ($rose(hresetn) |-> ##1 pwm_frequency_hz == 15'h07D0 &&
    reference_ratio == 10'h200 && low_supply_threshold_v == 5'h08) else $error("reset decode");
  a_reserved_read_zero: assert property (dp_rd |-> hrdata[31:8] == 24'h000000 &&
    (dp_idx != IDX_REG_DIM_ADDR || (!hrdata[7] && !hrdata[5]))) else $error("reserved read");
endmodule

bind nvcfg_bank nvcfg_bank_checker #(.PERIOD_NS(PERIOD_NS)) nvcfg_bank_checker_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .diag_enable_ch_eight(diag_enable_ch_eight), .diag_enable_ch_nine(diag_enable_ch_nine),
  .diag_enable_ch_ten(diag_enable_ch_ten), .diag_enable_ch_eleven(diag_enable_ch_eleven),
  .regulator_voltage_select(regulator_voltage_select),
  .exponential_dimming_enable(exponential_dimming_enable),
  .address_source_select(address_source_select), .device_address(device_address),
  .failure_policy_select(failure_policy_select), .pwm_frequency_hz(pwm_frequency_hz),
  .reference_ratio(reference_ratio), .low_supply_threshold_v(low_supply_threshold_v)
);

// ==== tb_nvcfg_bank.sv ====
module tb_nvcfg_bank
  import nvcfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PER_NS = 100;
  localparam int PWM_EXP [16] = '{200, 250, 300, 350, 400, 500, 600, 800,
                                  1000, 1200, 2000, 4000, 5900, 7800, 9600, 20800};
  localparam int TMO_US [8] = '{1000, 125, 250, 500, 1250, 2500, 5000, 10000};
  localparam logic [IDX_W-1:0] IDXS [4] = '{IDX_UPPER_DIAG, IDX_REG_DIM_ADDR,
                                            IDX_PWM_FAIL, IDX_TMO_SUPPLY};
  localparam logic [7:0] RSTS [4] = '{8'h0F, 8'h00, 8'hA7, 8'h03};
  localparam logic [7:0] MASKS [4] = '{8'h0F, 8'h5F, 8'hFF, 8'h7F};
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize, strap;
  logic [31:0] haddr, hwdata, hrdata;
  logic d8, d9, d10, d11, rsel, expd, src, fpol;
  logic [3:0] dev;
  logic [14:0] pwm;
  logic [9:0] rat;
  logic [19:0] tmo;
  logic [4:0] sup;
  int error_cnt = 0;
  int total_checks = 0;
  nvcfg_bank #(.PERIOD_NS(PER_NS)) nvcfg_bank_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .address_strap_pin_2(strap[2]), .address_strap_pin_1(strap[1]),
    .address_strap_pin_0(strap[0]), .diag_enable_ch_eight(d8), .diag_enable_ch_nine(d9),
    .diag_enable_ch_ten(d10), .diag_enable_ch_eleven(d11), .regulator_voltage_select(rsel),
    .exponential_dimming_enable(expd), .address_source_select(src), .device_address(dev),
    .failure_policy_select(fpol), .pwm_frequency_hz(pwm), .reference_ratio(rat),
    .link_timeout_cycles(tmo), .low_supply_threshold_v(sup)
  );
  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 64);
    chk("ready", {31'h0, hreadyout}, 32'h1);
  endtask
  task automatic bus(input logic wr, input logic [IDX_W-1:0] i, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {20'h0, i, 2'b00};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
    chk("resp", {31'h0, hresp}, {31'h0, HRESP_OKAY});
  endtask
  task automatic wreg(input logic [IDX_W-1:0] i, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, i, d, q);
  endtask
  task automatic rreg(input logic [IDX_W-1:0] i, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, i, 32'h0, q);
    chk("read", q, exp);
  endtask
  // Checks every setting output once the last write has propagated
  task automatic outs(input logic [3:0] dg, input logic [3:0] fl, input logic [3:0] da,
                      input logic [31:0] ep, input logic [31:0] er, input logic [31:0] et,
                      input logic [31:0] es);
    repeat (2) @(posedge hclk);
    chk("diag", {28'h0, d11, d10, d9, d8}, {28'h0, dg});
    chk("flags", {28'h0, rsel, expd, src, fpol}, {28'h0, fl});
    chk("addr", {28'h0, dev}, {28'h0, da});
    chk("pwm", {17'h0, pwm}, ep);
    chk("ratio", {22'h0, rat}, er);
    chk("timeout", {12'h0, tmo}, et);
    chk("supply", {27'h0, sup}, es);
  endtask
  task automatic rst_pulse;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
  endtask
  task automatic check_reset(input logic [3:0] da);
    outs(4'hF, 4'b0001, da, 2000, 512, 10000, 8);
    for (int i = 0; i < 4; i++)
    begin
      rreg(IDXS[i], {24'h0, RSTS[i]});
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
    begin
      $display("DONE - PASS");
    end
    else
    begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    strap = 3'h5;
    rst_pulse();
    check_reset(4'h5);
    $display("test reset finished");
    for (int i = 0; i < 4; i++)
    begin
      wreg(IDXS[i], 32'hFFFFFFFF);
      rreg(IDXS[i], {24'h0, MASKS[i]});
    end
    wreg(10'h0C9, 32'hFFFFFFFF);
    rreg(10'h0C9, 32'h0);
    outs(4'hF, 4'hF, 4'hF, 20800, 512, 100000, 20);
    for (int i = 0; i < 4; i++)
    begin
      wreg(IDXS[i], 32'h0);
    end
    outs(4'h0, 4'h0, 4'h5, 200, 64, 10000, 5);
    $display("test masks finished");
    for (int c = 0; c < 16; c++)
    begin
      wreg(IDX_REG_DIM_ADDR, c);
      wreg(IDX_PWM_FAIL, {c[3:0], 1'b1, c[0], c[1:0]});
      wreg(IDX_TMO_SUPPLY, {1'b0, c[2:0], c[3:0]});
      outs(4'h0, {3'b001, c[0]}, c, PWM_EXP[c], 64 << c[1:0], TMO_US[c % 8] * 1000 / PER_NS, 5 + c);
    end
    $display("test decode finished");
    wreg(IDX_PWM_FAIL, 32'h0);
    for (int s = 0; s < 8; s++)
    begin
      strap <= s;
      repeat (8) @(posedge hclk);
      chk("strap", {28'h0, dev}, s);
    end
    $display("test straps finished");
    wreg(IDX_UPPER_DIAG, 32'h0);
    rst_pulse();
    check_reset(4'h7);
    $display("test rerun finished");
    stop_test();
  end
  initial
  begin
    repeat (20000) @(posedge hclk);
    error_cnt++;
    $display("[ERR] %0t: watchdog expired", $time);
    stop_test();
  end
endmodule
